// ---- core/flash_guard.sv ----
// Contract
// [R1] 1024-byte otp, 32 lockable 32-byte regions
// [R2] otp read uses fast read protocol
// [R3] otp reads past 1 kB undefined
// [R4] otp program repeatable, never erased
// [R5] out-of-range otp program dropped silently
// [R6] in-range otp program under freeze errors
// [R7] lock byte bit n guards region n
// [R8] bit0 at 0x10 guards region0 upper half
// [R9] write enable command sets write latch
// [R10] listed commands clear the write latch
// [R11] range bits pick protected array fraction
// [R12] bottom select anchors range top/bottom
// [R13] range and sector protection ORed
// [R14] host should not mix both schemes
// [R15] freeze holds range and bottom bits
// [R16] freeze cleared only by power-on
// [R17] range bits writable while unfrozen
// [R18] freeze protects whole otp space
// [R19] frozen range write ignored, no error
// [R20] guard pin low plus guard bit locks registers
// [R21] program error flag is status bit 6
// [R22] sector guarded if either bit zero
// [R23] no write latch, modifying command ignored
// [R24] locked otp region program errors
`timescale 1ns/1ns
`default_nettype none
module flash_guard
  import flash_guard_pkg::*;
#(
  parameter int OTP_SIZE = OTP_BYTES
) (
  // clock and control
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic por,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // pins and sector bits
  input wire logic guard_pin_n,
  input wire logic persistent_sector_bit,
  input wire logic dynamic_sector_bit,
  // verdict outputs
  output logic write_latch_flag,
  output logic array_write_ok,
  output logic otp_read_valid,
  output logic [7:0] otp_read_data
);
  // ----------------------------------------------------------------
  // local sizes
  // ----------------------------------------------------------------
  localparam int LOCK_SPAN = 8;
  localparam int REGION_BITS = 5;
  localparam int REGION_LSB = 5;
  localparam logic [REGION_BITS-1:0] FIRST_REGION = '0;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [7:0] otp_mem [OTP_SIZE];
  // protection settings
  logic [2:0] range_protect_bits;
  logic bottom_select_bit;
  logic freeze;
  logic status_write_guard;

  // error flag and captured request
  logic prog_error;
  request_s req;
  logic go;

  // ----------------------------------------------------------------
  // decode results and command strobes
  // ----------------------------------------------------------------
  // address decode
  logic [OTP_AW-1:0] otp_addr;
  logic [REGION_BITS-1:0] region;
  logic region0_lower;
  logic [OTP_REGIONS-1:0] lock_bits;
  logic otp_hit;
  logic region_locked;
  logic otp_ok;
  logic range_hit;
  logic sector_locked;
  logic reg_locked;

  // strobes
  logic enable_go;
  logic latch_clear_go;
  logic reg_write_taken;
  logic onetime_write_go;
  logic onetime_read_go;
  logic array_program_go;
  logic array_write_go;
  logic next_prog_error;

  // read path
  logic [7:0] status_byte;
  logic [7:0] config_byte;
  logic [7:0] verdict_byte;
  logic [7:0] next_rdata;

  // ----------------------------------------------------------------
  // request capture
  // ----------------------------------------------------------------
  // a command write alone starts execution, one cycle later
  always_ff @(posedge clk) begin
    if (srst) begin
      go <= 1'b0;
    end else if (ce) begin
      go <= reg_wr && reg_addr == REG_CMD;
    end
  end

  // address bytes shift in msb first; the first data write moves to the
  // status slot when the second arrives, so the host must keep that order
  always_ff @(posedge clk) begin
    if (srst) begin
      req <= '0;
    end else if (ce && reg_wr) begin
      if (reg_addr == REG_ADDR) begin
        req.addr <= {req.addr[ARRAY_AW-9:0], reg_wdata};
      end else if (reg_addr == REG_DATA) begin
        req.sr_data <= req.cr_data;
        req.cr_data <= reg_wdata;
      end else if (reg_addr == REG_CMD) begin
        req.cmd <= cmd_e'(reg_wdata[3:0]);
      end
    end
  end

  // ----------------------------------------------------------------
  // protection decode
  // ----------------------------------------------------------------
  // a top-anchored range needs its top sh address bits all set; the bottom
  // anchor runs the same compare on the inverted address
  function automatic logic in_range(input logic [2:0] bits, input logic bottom,
                                    input logic [ARRAY_AW-1:0] a);
    logic [ARRAY_AW-1:0] probe;
    logic [ARRAY_AW-1:0] mask;
    logic [4:0] sh;
    probe = bottom ? ~a : a;
    sh = RANGE_SHIFT_BASE - 5'(bits);
    mask = ~({ARRAY_AW{1'b1}} >> sh);
    if (bits == RANGE_NONE) begin
      in_range = 1'b0;
    end else if (bits == RANGE_ALL) begin
      in_range = 1'b1;
    end else begin
      in_range = (probe & mask) == mask; // [R11] [R12]
    end
  endfunction : in_range

  // commands that end with the write latch dropped
  function automatic logic clears_latch(input cmd_e c);
    case (c)
      CMD_WRITE_DISABLE, CMD_REGISTER_WRITE, CMD_PAGE_PROGRAM, CMD_REGION_WIPE,
      CMD_CHIP_WIPE, CMD_QUAD_PAGE, CMD_ONETIME_WRITE, CMD_SOFT_RESET: clears_latch = 1'b1;
      default: clears_latch = 1'b0;
    endcase
  endfunction : clears_latch

  // main-array programs, the ones that can raise the error flag
  function automatic logic is_array_program(input cmd_e c);
    case (c)
      CMD_PAGE_PROGRAM, CMD_QUAD_PAGE: is_array_program = 1'b1;
      default: is_array_program = 1'b0;
    endcase
  endfunction : is_array_program

  // main-array commands that the write verdict covers
  function automatic logic is_array_write(input cmd_e c);
    case (c)
      CMD_PAGE_PROGRAM, CMD_QUAD_PAGE, CMD_REGION_WIPE: is_array_write = 1'b1;
      default: is_array_write = 1'b0;
    endcase
  endfunction : is_array_write

  assign otp_addr = req.addr[OTP_AW-1:0];
  // programs past the otp space are dropped without an error
  assign otp_hit = req.addr < ARRAY_AW'(OTP_SIZE); // [R1] [R5]
  assign region = otp_addr[REGION_LSB +: REGION_BITS];
  assign region0_lower = region == FIRST_REGION && otp_addr < REGION0_UPPER;

  // one lock bit per region: lock byte k covers regions 8k to 8k+7
  genvar g;
  generate
    for (g = 0; g < OTP_REGIONS; g++) begin : g_lock
      assign lock_bits[g] = otp_mem[LOCK_BASE + OTP_AW'(g / LOCK_SPAN)][g % LOCK_SPAN]; // [R7]
    end
  endgenerate

  // region 0 lower half lies outside the lock bytes' cover; its upper half,
  // the lock bytes themselves, answers to bit 0 of the first lock byte
  assign region_locked = region0_lower ? 1'b0 : ~lock_bits[region]; // [R7] [R8] [R24]
  assign otp_ok = otp_hit && !freeze && !region_locked; // [R18]
  assign range_hit = in_range(range_protect_bits, bottom_select_bit, req.addr);
  assign sector_locked = range_hit || !persistent_sector_bit || !dynamic_sector_bit; // [R13] [R22]
  assign reg_locked = !guard_pin_n && status_write_guard; // [R20]

  // ----------------------------------------------------------------
  // command strobes, one cycle after the command write
  // ----------------------------------------------------------------
  assign enable_go = go && req.cmd == CMD_WRITE_ENABLE; // [R9]
  assign latch_clear_go = go && clears_latch(req.cmd); // [R10]
  assign reg_write_taken = go && req.cmd == CMD_REGISTER_WRITE && write_latch_flag && !reg_locked; // [R20] [R23]
  assign onetime_write_go = go && req.cmd == CMD_ONETIME_WRITE && write_latch_flag; // [R23]
  assign onetime_read_go = go && req.cmd == CMD_ONETIME_READ; // [R2]
  assign array_program_go = go && is_array_program(req.cmd) && write_latch_flag;
  assign array_write_go = go && is_array_write(req.cmd) && write_latch_flag && !sector_locked; // [R23]

  // ----------------------------------------------------------------
  // write latch
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst || por) begin
      write_latch_flag <= 1'b0; // [R10]
    end else if (ce) begin
      if (enable_go) begin
        write_latch_flag <= 1'b1; // [R9]
      end else if (latch_clear_go) begin
        write_latch_flag <= 1'b0; // [R10]
      end
    end
  end

  // ----------------------------------------------------------------
  // guard, freeze, range and bottom bits: por only, srst leaves them
  // ----------------------------------------------------------------
  // a soft reset must not reopen a guarded register set
  always_ff @(posedge clk) begin
    if (por) begin
      status_write_guard <= 1'b0;
    end else if (ce && reg_write_taken) begin
      status_write_guard <= req.sr_data[SR_GUARD]; // [R20]
    end
  end

  // freeze is or-ed in, so no register write can take it back
  always_ff @(posedge clk) begin
    if (por) begin
      freeze <= 1'b0; // [R16]
    end else if (ce && reg_write_taken) begin
      freeze <= freeze | req.cr_data[CR_FREEZE]; // [R16]
    end
  end

  // a frozen write drops these fields without raising any error
  always_ff @(posedge clk) begin
    if (por) begin
      range_protect_bits <= RANGE_NONE;
    end else if (ce && reg_write_taken && !freeze) begin
      range_protect_bits <= req.sr_data[SR_RANGE_LO +: 3]; // [R17] [R19]
    end
  end

  always_ff @(posedge clk) begin
    if (por) begin
      bottom_select_bit <= 1'b0;
    end else if (ce && reg_write_taken && !freeze) begin
      bottom_select_bit <= req.cr_data[CR_BOTTOM]; // [R15] [R17]
    end
  end

  // ----------------------------------------------------------------
  // otp program and error flag; no erase path exists for otp
  // ----------------------------------------------------------------
  // programming only clears bits, so repeats on one byte are harmless
  always_ff @(posedge clk) begin
    if (ce && onetime_write_go && otp_ok) begin
      otp_mem[otp_addr] <= otp_mem[otp_addr] & req.cr_data; // [R4]
    end
  end

  // set wins over clear; both come from one command so they never meet
  always_comb begin
    next_prog_error = prog_error;
    if (onetime_write_go && otp_hit && !otp_ok) begin
      next_prog_error = 1'b1; // [R6] [R21] [R24]
    end else if (array_program_go && sector_locked) begin
      next_prog_error = 1'b1; // [R21]
    end else if (go && req.cmd == CMD_SOFT_RESET) begin
      next_prog_error = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst || por) begin
      prog_error <= 1'b0;
    end else if (ce) begin
      prog_error <= next_prog_error;
    end
  end

  // ----------------------------------------------------------------
  // verdicts and otp read
  // ----------------------------------------------------------------
  // one-cycle pulse per allowed page program, quad page or region wipe
  always_ff @(posedge clk) begin
    if (srst) begin
      array_write_ok <= 1'b0;
    end else if (ce) begin
      array_write_ok <= array_write_go; // [R23]
    end
  end

  // one-cycle pulse per otp read
  always_ff @(posedge clk) begin
    if (srst) begin
      otp_read_valid <= 1'b0;
    end else if (ce) begin
      otp_read_valid <= onetime_read_go; // [R2]
    end
  end

  // beyond 1 kB the address wraps; data there has no meaning
  always_ff @(posedge clk) begin
    if (srst) begin
      otp_read_data <= '0;
    end else if (ce && onetime_read_go) begin
      otp_read_data <= otp_mem[otp_addr]; // [R3]
    end
  end

  // ----------------------------------------------------------------
  // register read port
  // ----------------------------------------------------------------
  assign status_byte = {status_write_guard, prog_error, 1'b0, range_protect_bits, write_latch_flag, 1'b0}; // [R21]
  assign config_byte = {2'b00, bottom_select_bit, 4'h0, freeze};
  assign verdict_byte = {4'h0, reg_locked, sector_locked, range_hit, otp_ok};

  // zero outside the read slot keeps stale data off the bus
  always_comb begin
    next_rdata = '0;
    if (!reg_rd) begin
      next_rdata = '0;
    end else if (reg_addr == REG_STATUS) begin
      next_rdata = status_byte;
    end else if (reg_addr == REG_CONFIG) begin
      next_rdata = config_byte;
    end else if (reg_addr == REG_VERDICT) begin
      next_rdata = verdict_byte;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      reg_rdata <= '0;
    end else if (ce) begin
      reg_rdata <= next_rdata;
    end
  end
endmodule : flash_guard
`default_nettype wire

// ---- core/flash_guard_pkg.sv ----
package flash_guard_pkg;
  // ----------------------------------------------------------------
  // command opcodes as seen by the protection logic
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    CMD_NONE           = 4'b0000,
    CMD_WRITE_ENABLE   = 4'b0001,
    CMD_WRITE_DISABLE  = 4'b0010,
    CMD_REGISTER_WRITE = 4'b0011,
    CMD_PAGE_PROGRAM   = 4'b0100,
    CMD_REGION_WIPE    = 4'b0101,
    CMD_CHIP_WIPE      = 4'b0110,
    CMD_QUAD_PAGE      = 4'b0111,
    CMD_ONETIME_WRITE  = 4'b1000,
    CMD_ONETIME_READ   = 4'b1001,
    CMD_SOFT_RESET     = 4'b1010
  } cmd_e;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int OTP_BYTES = 1024;
  localparam int OTP_REGION_BYTES = 32;
  localparam int OTP_REGIONS = 32;
  localparam int OTP_AW = 10;
  localparam int ARRAY_AW = 24;
  localparam logic [OTP_AW-1:0] LOCK_BASE = 10'h010;
  localparam logic [OTP_AW-1:0] LOCK_LAST = 10'h013;
  localparam logic [OTP_AW-1:0] REGION0_UPPER = 10'h010;
  localparam logic [7:0] OTP_ERASED = 8'hFF;

  // ----------------------------------------------------------------
  // status / configuration bit positions
  // ----------------------------------------------------------------
  localparam int SR_BUSY = 0;
  localparam int SR_LATCH = 1;
  localparam int SR_RANGE_LO = 2;
  localparam int SR_PERR = 6;
  localparam int SR_GUARD = 7;
  localparam int CR_FREEZE = 0;
  localparam int CR_BOTTOM = 5;
  localparam logic [2:0] RANGE_NONE = 3'b000;
  localparam logic [2:0] RANGE_ALL = 3'b111;
  localparam logic [4:0] RANGE_SHIFT_BASE = 5'h07;

  // ----------------------------------------------------------------
  // register port offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_CONFIG = 4'h1;
  localparam logic [3:0] REG_CMD = 4'h2;
  localparam logic [3:0] REG_ADDR = 4'h3;
  localparam logic [3:0] REG_DATA = 4'h4;
  localparam logic [3:0] REG_VERDICT = 4'h5;

  typedef struct packed {
    logic [ARRAY_AW-1:0] addr;
    logic [7:0] sr_data;
    logic [7:0] cr_data;
    cmd_e cmd;
  } request_s;
endpackage : flash_guard_pkg

// ---- testbench/flash_guard_props.sv ----
`timescale 1ns/1ns
`default_nettype none
module flash_guard_props
  import flash_guard_pkg::*;
(
  // clock and control
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic por,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // verdicts
  input wire logic write_latch_flag,
  input wire logic array_write_ok,
  input wire logic otp_read_valid
);
  logic cw;
  assign cw = ce && reg_wr && reg_addr == REG_CMD;
  default clocking @(posedge clk); endclocking
  default disable iff (srst || por);
  latch_set_a: assert property (cw && reg_wdata == 8'h01 |-> ##2 write_latch_flag)
    else $error("latch not set by enable");
  latch_clear_a: assert property (cw && reg_wdata inside {[8'h02:8'h08], 8'h0A} |-> ##2 !write_latch_flag)
    else $error("latch not cleared");
  latch_cause_a: assert property ($rose(write_latch_flag) |-> $past(cw && reg_wdata == 8'h01, 2))
    else $error("latch rose without enable");
  latch_drop_a: assert property ($fell(write_latch_flag) |-> $past(cw, 2))
    else $error("latch fell without command");
  write_gate_a: assert property (array_write_ok |-> $past(write_latch_flag))
    else $error("write allowed without latch");
  read_cause_a: assert property (otp_read_valid |-> $past(cw && reg_wdata == 8'h09, 2))
    else $error("otp read without command");
  rdata_idle_a: assert property (!$past(reg_rd && ce) |-> reg_rdata == 8'h00)
    else $error("read data outside read slot");
  reset_clear_a: assert property (disable iff (1'b0) srst || por |=> !write_latch_flag && !array_write_ok)
    else $error("reset left latch or verdict");
  cover property (array_write_ok);
  cover property (otp_read_valid);
  cover property ($rose(write_latch_flag));
endmodule : flash_guard_props
bind flash_guard flash_guard_props i_props (.*);
`default_nettype wire

// ---- testbench/flash_host.sv ----
`timescale 1ns/1ns
`default_nettype none
module flash_host
  import flash_guard_pkg::*;
(
  // register port
  input wire logic clk,
  output logic [3:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata
);
  initial begin
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_rd <= 1'b0;
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
  endtask : wr
  // idle lines flip so a stale value never passes for a live one
  task automatic idle();
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    reg_addr <= ~reg_addr;
    reg_wdata <= ~reg_wdata;
  endtask : idle
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    reg_addr <= a;
    idle();
    @(negedge clk);
    d = reg_rdata;
  endtask : rd
  task automatic ld(input logic [23:0] a, input logic [7:0] s, input logic [7:0] c);
    wr(REG_ADDR, a[23:16]);
    wr(REG_ADDR, a[15:8]);
    wr(REG_ADDR, a[7:0]);
    wr(REG_DATA, s);
    wr(REG_DATA, c);
  endtask : ld
  // gap keeps the next command clear of the one executing
  task automatic go(input logic [3:0] code);
    wr(REG_CMD, {4'h0, code});
    idle();
    repeat (3) @(posedge clk);
  endtask : go
endmodule : flash_host
`default_nettype wire

// ---- testbench/tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin fails++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end
module tb_top;
  import flash_guard_pkg::*;
  logic clk = 0, srst = 1, ce = 1, por = 1, guard_pin_n = 1, psb = 1, dsb = 1;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, v, otp_read_data;
  logic reg_wr, reg_rd, write_latch_flag, array_write_ok, otp_read_valid, ok_seen, rd_seen;
  int fails = 0, samples_checked = 0;
  cmd_e clr[7] = '{CMD_WRITE_DISABLE, CMD_REGISTER_WRITE, CMD_PAGE_PROGRAM, CMD_REGION_WIPE,
                   CMD_CHIP_WIPE, CMD_QUAD_PAGE, CMD_SOFT_RESET};
  always #25 clk = ~clk;
  flash_host i_host (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  flash_guard i_dut (.clk(clk), .srst(srst), .ce(ce), .por(por), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .guard_pin_n(guard_pin_n), .persistent_sector_bit(psb), .dynamic_sector_bit(dsb),
    .write_latch_flag(write_latch_flag), .array_write_ok(array_write_ok),
    .otp_read_valid(otp_read_valid), .otp_read_data(otp_read_data));
  always @(posedge clk) begin
    if (array_write_ok) ok_seen <= 1'b1;
    if (otp_read_valid) rd_seen <= 1'b1;
  end
  task automatic chk(input logic [3:0] a, input logic [7:0] e);
    i_host.rd(a, v);
    `CHK("register", e, v)
  endtask : chk
  task automatic wreg(input logic [7:0] s, input logic [7:0] c);
    i_host.ld(24'h000000, s, c);
    i_host.go(CMD_WRITE_ENABLE);
    i_host.go(CMD_REGISTER_WRITE);
  endtask : wreg
  task automatic prog(input logic [23:0] a, input logic e);
    ok_seen = 1'b0;
    i_host.ld(a, 8'h00, 8'h00);
    i_host.go(CMD_WRITE_ENABLE);
    i_host.go(CMD_PAGE_PROGRAM);
    `CHK("write_ok", e, ok_seen)
  endtask : prog
  task automatic results();
    $display("checks %0d fails %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : results
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    results();
  end
  initial begin
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    por <= 1'b0;
    chk(REG_STATUS, 8'h00);
    i_host.ld(24'h000000, 8'h00, 8'h00);
    i_host.go(CMD_WRITE_ENABLE);
    chk(REG_STATUS, 8'h02);
    foreach (clr[i]) begin
      i_host.go(CMD_WRITE_ENABLE);
      i_host.go(clr[i]);
      `CHK("latch", 1'b0, write_latch_flag)
    end
    $display("test latch done");
    wreg(8'h14, 8'h00);
    chk(REG_STATUS, 8'h14);
    i_host.ld(24'h000000, 8'h04, 8'h00);
    i_host.go(CMD_REGISTER_WRITE);
    chk(REG_STATUS, 8'h14);
    prog(24'hBFFFFF, 1'b1);
    prog(24'hC00000, 1'b0);
    wreg(8'h14, 8'h20);
    prog(24'h3FFFFF, 1'b0);
    prog(24'h400000, 1'b1);
    dsb <= 1'b0;
    prog(24'h400000, 1'b0);
    dsb <= 1'b1;
    wreg(8'h1C, 8'h00);
    prog(24'h000000, 1'b0);
    chk(REG_STATUS, 8'h5C);
    i_host.go(CMD_SOFT_RESET);
    chk(REG_STATUS, 8'h1C);
    $display("test range done");
    wreg(8'h80, 8'h00);
    guard_pin_n <= 1'b0;
    wreg(8'h00, 8'h00);
    chk(REG_STATUS, 8'h80);
    guard_pin_n <= 1'b1;
    wreg(8'h14, 8'h01);
    wreg(8'h08, 8'h00);
    chk(REG_STATUS, 8'h14);
    chk(REG_CONFIG, 8'h01);
    i_host.ld(24'h000400, 8'h00, 8'h00);
    i_host.go(CMD_WRITE_ENABLE);
    i_host.go(CMD_ONETIME_WRITE);
    chk(REG_STATUS, 8'h14);
    i_host.ld(24'h000020, 8'h00, 8'h00);
    i_host.go(CMD_WRITE_ENABLE);
    i_host.go(CMD_ONETIME_WRITE);
    chk(REG_STATUS, 8'h54);
    @(posedge clk) srst <= 1'b1;
    @(posedge clk) srst <= 1'b0;
    chk(REG_CONFIG, 8'h01);
    rd_seen = 1'b0;
    i_host.go(CMD_ONETIME_READ);
    `CHK("otp_read", 1'b1, rd_seen)
    @(posedge clk) por <= 1'b1;
    @(posedge clk) por <= 1'b0;
    chk(REG_CONFIG, 8'h00);
    i_host.ld(24'h000005, 8'h00, 8'h00);
    i_host.go(CMD_WRITE_ENABLE);
    i_host.go(CMD_ONETIME_WRITE);
    chk(REG_STATUS, 8'h00);
    i_host.go(CMD_ONETIME_READ);
    `CHK("otp_data", 8'h00, otp_read_data)
    $display("test freeze done");
    results();
  end
endmodule : tb_top
`default_nettype wire
